// ---- src/usi_status_top.sv ----
// usi_status_top: status, mask, interrupt and channel loop logic of
// one serial channel, with a plain register port.
// assumes receiver, transmitter, baud and buffer-transfer logic sit
// outside on the same clock; rxd_pin comes from outside that domain.
module usi_status_top
    import usi_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    // serial pins
    input  wire logic          rxd_pin,
    output logic               txd_pin,
    output logic               sck_out,
    output logic               sck_oe,
    // receiver and transmitter
    input  wire logic          tx_serial,
    output logic               rx_serial,
    input  wire logic          baud_clk_level,
    input  wire usi_rx_evt_t   rx_evt,
    input  wire logic [8:0]    rx_hold_data,
    input  wire usi_tx_state_t tx_st,
    output logic               rx_hold_read,
    output logic               rx_enabled,
    output logic               tx_enabled,
    output logic      [3:0]    char_bits,
    // buffer transfer and time-out
    input  wire logic          rx_xfer_end,
    input  wire logic          tx_xfer_end,
    input  wire logic          timeout_expired,
    output logic               idle_wait_start,
    output logic      [7:0]    idle_time_value,
    // interrupt
    output logic               irq
);

    // ---------------------------------------------------------------
    // reset release and pin synchroniser
    // ---------------------------------------------------------------
    logic rst_meta_reg, rst_n;
    logic rxd_meta_reg, rxd_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_meta_reg <= 1'b1;
            rxd_s        <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd_pin;
            rxd_s        <= rxd_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    logic wr_cmd, wr_mode, wr_set, wr_clr, wr_idle, rd_hold;
    logic cmd_rst_status, cmd_idle;

    // read-only offsets have no write decode
    assign wr_cmd  = reg_wr && (reg_addr == OFS_COMMAND);
    assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
    assign wr_set  = reg_wr && (reg_addr == OFS_MASK_SET);
    assign wr_clr  = reg_wr && (reg_addr == OFS_MASK_CLR);
    assign wr_idle = reg_wr && (reg_addr == OFS_IDLE_TIME);
    assign rd_hold = reg_rd && (reg_addr == OFS_RX_HOLD);
    assign cmd_rst_status = wr_cmd && reg_wdata[CMD_RST_STATUS];
    // a time-out value write also starts the wait
    assign cmd_idle = (wr_cmd && reg_wdata[CMD_START_IDLE]) || wr_idle;

    // ---------------------------------------------------------------
    // mode, mask and time-out value registers
    // ---------------------------------------------------------------
    logic [31:0] mode_reg;
    logic [9:0]  mask_reg;
    logic [7:0]  idle_reg;
    usi_loop_t   loop_mode;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= reg_wdata & MODE_WR_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= MASK_RESET;
        end else if (wr_set) begin
            mask_reg <= usi_mask_next(mask_reg, reg_wdata[9:0], 1'b1);
        end else if (wr_clr) begin
            mask_reg <= usi_mask_next(mask_reg, reg_wdata[9:0], 1'b0);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= IDLE_RESET;
        end else if (wr_idle) begin
            idle_reg <= reg_wdata[7:0];
        end
    end

    assign loop_mode = usi_loop_t'(mode_reg[MODE_LOOP_LSB +: 2]);
    assign idle_time_value = idle_reg;

    // ---------------------------------------------------------------
    // enables and receive ready
    // ---------------------------------------------------------------
    logic rx_en_reg, tx_en_reg, rx_ready_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
        end else if (wr_cmd) begin
            if (reg_wdata[CMD_RX_DIS]) begin
                rx_en_reg <= 1'b0;
            end else if (reg_wdata[CMD_RX_EN]) begin
                rx_en_reg <= 1'b1;
            end
            if (reg_wdata[CMD_TX_DIS]) begin
                tx_en_reg <= 1'b0;
            end else if (reg_wdata[CMD_TX_EN]) begin
                tx_en_reg <= 1'b1;
            end
        end
    end

    // a character arriving in a holding-read cycle keeps the flag set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ready_reg <= 1'b0;
        end else if (rx_evt.char_done && rx_en_reg) begin
            rx_ready_reg <= 1'b1;
        end else if (rd_hold || !rx_en_reg) begin
            rx_ready_reg <= 1'b0;
        end
    end

    assign rx_hold_read = rd_hold;
    assign rx_enabled   = rx_en_reg;
    assign tx_enabled   = tx_en_reg;

    // ---------------------------------------------------------------
    // sticky error flags: break, overrun, framing, parity
    // ---------------------------------------------------------------
    logic [3:0] err_set, err_q;
    logic       multidrop;

    assign multidrop = (mode_reg[MODE_PARITY_LSB+1 +: 2] == PAR_MULTIDROP);
    assign err_set[0] = rx_evt.break_edge;
    assign err_set[1] = rx_evt.char_done && rx_ready_reg;
    assign err_set[2] = rx_evt.stop_low;
    assign err_set[3] = rx_evt.parity_bad
                        || (multidrop && rx_evt.parity_high);

    usi_sticky #(
        .W      (4)
    ) u_err (
        .clk    (clk),
        .rst_n  (rst_n),
        .set_v  (err_set),
        .clr    (cmd_rst_status),
        .flag_q (err_q)
    );

    // ---------------------------------------------------------------
    // time-out flag and wait start
    // ---------------------------------------------------------------
    logic timeout_reg, idle_start_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_reg <= 1'b0;
        end else if (idle_reg == IDLE_RESET) begin
            timeout_reg <= 1'b0;
        end else if (timeout_expired) begin
            timeout_reg <= 1'b1;
        end else if (cmd_idle) begin
            timeout_reg <= 1'b0;
        end
    end

    // the counter outside arms on this pulse and waits for a character
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_start_reg <= 1'b0;
        end else begin
            idle_start_reg <= cmd_idle;
        end
    end

    assign idle_wait_start = idle_start_reg;

    // ---------------------------------------------------------------
    // status vector and interrupt
    // ---------------------------------------------------------------
    logic [9:0] status;
    logic       irq_reg;

    always_comb begin
        status                = '0;
        status[ST_RX_READY]   = rx_ready_reg;
        status[ST_TX_READY]   = tx_en_reg && !tx_st.holding_full
                                && !tx_st.break_pending;
        status[ST_BREAK]      = err_q[0];
        status[ST_RX_END]     = rx_xfer_end;
        status[ST_TX_END]     = tx_xfer_end;
        status[ST_OVERRUN]    = err_q[1];
        status[ST_FRAMING]    = err_q[2];
        status[ST_PARITY]     = err_q[3];
        status[ST_TIMEOUT]    = timeout_reg;
        status[ST_TX_DRAINED] = tx_en_reg && !tx_st.holding_full
                                && !tx_st.shifter_busy && !tx_st.break_active;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status & mask_reg);
        end
    end

    assign irq = irq_reg;

    // ---------------------------------------------------------------
    // read data, one cycle after the strobe
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_MODE:      reg_rdata <= mode_reg;
                OFS_MASK_VIEW: reg_rdata <= {22'h0, mask_reg};
                OFS_STATUS:    reg_rdata <= {22'h0, status};
                OFS_RX_HOLD:   reg_rdata <= {23'h0, rx_hold_data};
                OFS_IDLE_TIME: reg_rdata <= {24'h0, idle_reg};
                default:       reg_rdata <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // channel loop routing, character length, clock pin
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_pin   <= 1'b1;
            rx_serial <= 1'b1;
        end else begin
            unique case (loop_mode)
                LOOP_NORMAL: begin
                    txd_pin   <= tx_serial;
                    rx_serial <= rxd_s;
                end
                LOOP_ECHO: begin
                    txd_pin   <= rxd_s;
                    rx_serial <= rxd_s;
                end
                LOOP_LOCAL: begin
                    txd_pin   <= 1'b1;
                    rx_serial <= tx_serial;
                end
                LOOP_REMOTE: begin
                    txd_pin   <= rxd_s;
                    rx_serial <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            char_bits <= BITS_BASE;
        end else if (mode_reg[MODE_NINE_BIT]) begin
            char_bits <= BITS_NINE;
        end else begin
            char_bits <= BITS_BASE + {2'b00, mode_reg[MODE_CHAR_LEN_LSB +: 2]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_oe  <= 1'b0;
            sck_out <= 1'b0;
        end else begin
            sck_oe  <= mode_reg[MODE_CLK_OUT]
                       && !mode_reg[MODE_CLK_SRC_LSB+1];
            sck_out <= baud_clk_level;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rst_cmd_quiet;
        cmd_rst_status && (err_set == 4'h0);
    endsequence

    a_mask_set: assert property (wr_set && reg_wdata[0] |=> mask_reg[0])
        else $error("mask set write lost");
    a_mask_clr: assert property (wr_clr && !wr_set |=>
        mask_reg == ($past(mask_reg) & ~$past(reg_wdata[9:0])))
        else $error("mask clear wrong");
    a_mask_view: assert property (reg_rd && reg_addr == OFS_MASK_VIEW
        |=> reg_rdata[9:0] == $past(mask_reg))
        else $error("mask view wrong");
    a_rx_ready: assert property (rx_evt.char_done && rx_en_reg
        |=> rx_ready_reg ##1 (rx_ready_reg || $past(rd_hold) || !$past(rx_en_reg)))
        else $error("receive ready not set");
    a_tx_ready: assert property (status[ST_TX_READY] |->
        !tx_st.holding_full && !tx_st.break_pending && tx_en_reg)
        else $error("transmit ready wrong");
    a_overrun: assert property (rx_evt.char_done && rx_ready_reg
        |=> status[ST_OVERRUN])
        else $error("overrun missed");
    a_rst_status: assert property (s_rst_cmd_quiet |=>
        status[ST_PARITY:ST_OVERRUN] == 3'h0 && !status[ST_BREAK])
        else $error("reset-status left a flag");
    a_irq_out: assert property (|(status & mask_reg) |=> irq)
        else $error("interrupt missing");
    a_timeout_zero: assert property (idle_reg == IDLE_RESET
        |=> !timeout_reg)
        else $error("time-out set with zero value");
    a_echo_path: assert property (loop_mode == LOOP_ECHO
        |=> txd_pin == $past(rxd_s))
        else $error("echo path broken");
    a_clock_pin: assert property (mode_reg[MODE_CLK_SRC_LSB+1]
        |=> !sck_oe)
        else $error("clock pin driven with outside source");
    a_nine_bits: assert property (mode_reg[MODE_NINE_BIT]
        |=> char_bits == BITS_NINE)
        else $error("nine-bit length wrong");

endmodule : usi_status_top

// ---- src/usi_pkg.sv ----
// usi_pkg: register map, field layout, reset values and carriers
// of the serial channel status and interrupt block.
// assumes one 100 MHz clock shared by all users.
package usi_pkg;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND   = 8'h00;
    localparam logic [7:0] OFS_MODE      = 8'h04;
    localparam logic [7:0] OFS_MASK_SET  = 8'h08;
    localparam logic [7:0] OFS_MASK_CLR  = 8'h0c;
    localparam logic [7:0] OFS_MASK_VIEW = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_RX_HOLD   = 8'h18;
    localparam logic [7:0] OFS_IDLE_TIME = 8'h24;

    // ---------------------------------------------------------------
    // status and mask bit positions
    // ---------------------------------------------------------------
    localparam int N_FLAGS       = 10;
    localparam int ST_RX_READY   = 0;
    localparam int ST_TX_READY   = 1;
    localparam int ST_BREAK      = 2;
    localparam int ST_RX_END     = 3;
    localparam int ST_TX_END     = 4;
    localparam int ST_OVERRUN    = 5;
    localparam int ST_FRAMING    = 6;
    localparam int ST_PARITY     = 7;
    localparam int ST_TIMEOUT    = 8;
    localparam int ST_TX_DRAINED = 9;

    // ---------------------------------------------------------------
    // command bits
    // ---------------------------------------------------------------
    localparam int CMD_RX_EN      = 4;
    localparam int CMD_RX_DIS     = 5;
    localparam int CMD_TX_EN      = 6;
    localparam int CMD_TX_DIS     = 7;
    localparam int CMD_RST_STATUS = 8;
    localparam int CMD_START_IDLE = 11;

    // ---------------------------------------------------------------
    // mode fields
    // ---------------------------------------------------------------
    localparam int MODE_CLK_SRC_LSB  = 4;
    localparam int MODE_CHAR_LEN_LSB = 6;
    localparam int MODE_PARITY_LSB   = 9;
    localparam int MODE_LOOP_LSB     = 14;
    localparam int MODE_NINE_BIT     = 17;
    localparam int MODE_CLK_OUT      = 18;
    localparam logic [31:0] MODE_WR_MASK = 32'h0006_fff0;

    // ---------------------------------------------------------------
    // reset values and fixed counts
    // ---------------------------------------------------------------
    localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
    localparam logic [9:0]  MASK_RESET   = 10'h000;
    localparam logic [9:0]  STATUS_RESET = 10'h018;
    localparam logic [7:0]  IDLE_RESET   = 8'h00;
    localparam logic [3:0]  BITS_NINE    = 4'h9;
    localparam logic [3:0]  BITS_BASE    = 4'h5;
    localparam logic [1:0]  PAR_MULTIDROP = 2'h3;

    typedef enum logic [1:0] {
        LOOP_NORMAL = 2'b00,
        LOOP_ECHO   = 2'b01,
        LOOP_LOCAL  = 2'b10,
        LOOP_REMOTE = 2'b11
    } usi_loop_t;

    // events from the receiver, one-cycle pulses
    typedef struct packed {
        logic char_done;
        logic stop_low;
        logic parity_bad;
        logic parity_high;
        logic break_edge;
    } usi_rx_evt_t;

    // levels from the transmitter
    typedef struct packed {
        logic holding_full;
        logic shifter_busy;
        logic break_active;
        logic break_pending;
    } usi_tx_state_t;

    function automatic logic [9:0] usi_mask_next(input logic [9:0] cur,
                                                input logic [9:0] wv,
                                                input logic       set);
        usi_mask_next = set ? (cur | wv) : (cur & ~wv);
    endfunction : usi_mask_next

endpackage : usi_pkg

// ---- src/usi_sticky.sv ----
// usi_sticky: a bank of sticky flags, set by hardware, cleared by command.
// assumes set and clear are synchronous to clk; set wins over clear.
module usi_sticky
    import usi_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic [W-1:0] set_v,
    input  wire logic         clr,
    // flags
    output logic      [W-1:0] flag_q
);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= set_v | (clr ? '0 : flag_q);
        end
    end

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (set_v != '0) |=> ((flag_q & $past(set_v)) == $past(set_v)))
        else $error("sticky flag lost its set");

endmodule : usi_sticky

// ---- tb/usi_remote_model.sv ----
// usi_remote_model: far-side serial device sending random bits on the line.
// assumes a bit period of BIT_CYC clocks; line idles high when not enabled.
module usi_remote_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic clk,
    input  wire logic en,
    output logic      rxd_line
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    int sd  = 2667;
    initial rxd_line = 1'b1;
    always @(posedge clk) begin
        cnt = (cnt + 1) % BIT_CYC;
        if (!en) begin
            rxd_line <= 1'b1;
        end else if (cnt == 0) begin
            rxd_line <= $random(sd);
        end
    end
endmodule : usi_remote_model

// ---- tb/usi_status_top_bench.sv ----
// usi_status_top_bench: register, flag, interrupt and loop checks.
// assumes the remote model drives the serial input pin.
module usi_status_top_bench;
    import usi_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, tx_serial = 1, baud = 0;
    logic rx_xfer_end = 1, tx_xfer_end = 1, to_exp = 0, en = 0, bp = 0;
    logic hr, rxe, txe, iws;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, v, w, m;
    logic [8:0] hold = '0, hp = '0;
    logic [3:0] char_bits;
    logic [7:0] idle_val;
    usi_rx_evt_t rx_evt = '0;
    usi_tx_state_t tx_st = '0;
    logic rxd_pin, txd_pin, sck_out, sck_oe, rx_serial, irq;
    int bad_count = 0, checked = 0, seed = 2667, i, k, hrc = 0, cyc = 0;
    always #5 clk = ~clk;
    usi_remote_model u_rm (.clk(clk), .en(en), .rxd_line(rxd_pin));
    usi_status_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rxd_pin(rxd_pin), .txd_pin(txd_pin), .sck_out(sck_out), .sck_oe(sck_oe),
        .tx_serial(tx_serial), .rx_serial(rx_serial), .baud_clk_level(baud),
        .rx_evt(rx_evt), .rx_hold_data(hold), .tx_st(tx_st), .rx_hold_read(hr),
        .rx_enabled(rxe), .tx_enabled(txe), .char_bits(char_bits),
        .rx_xfer_end(rx_xfer_end),
        .tx_xfer_end(tx_xfer_end), .timeout_expired(to_exp), .idle_wait_start(iws),
        .idle_time_value(idle_val), .irq(irq));
    // random side inputs, one-edge copies for expectations, holding read count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        baud <= $random(seed);
        hold <= $random(seed);
        if (cyc % 8 == 4) tx_serial <= $random(seed);
        bp <= baud;
        hp <= hold;
        hrc <= hrc + hr;
    end
    // ---------------------------------------------------------------
    // tasks and expectations
    // ---------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ev(input usi_rx_evt_t e);
        @(posedge clk) rx_evt <= e;
        @(posedge clk) rx_evt <= '0;
    endtask : ev
    // expected {txd_pin, rx_serial} per loop mode
    function automatic logic [1:0] loop_exp(input int md, input logic r, input logic t);
        case (md)
            0: loop_exp = {t, r};
            1: loop_exp = {r, r};
            2: loop_exp = {1'b1, t};
            default: loop_exp = {r, 1'b1};
        endcase
    endfunction : loop_exp
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        #200000 bad_count++;
        finish_test;
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        m = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFS_STATUS, v); chk(v, 32'h18);
        rd(OFS_MASK_VIEW, v); chk(v, 32'h0);
        rd(8'h3c, v); chk(v, 32'h0);
        for (i = 0; i < 8; i++) begin
            w = $random(seed) & 32'h3ff; wr(OFS_MASK_SET, w); m = m | w;
            w = $random(seed) & 32'h3ff; wr(OFS_MASK_CLR, w); m = m & ~w;
            wr(OFS_MASK_VIEW, 32'h3ff);
            rd(OFS_MASK_VIEW, v); chk(v, m);
        end
        wr(OFS_MASK_CLR, 32'h3ff);
        wr(OFS_COMMAND, 32'h50); #1 chk({rxe, txe}, 2'b11);
        rd(OFS_STATUS, v); chk(v, 32'h21a);
        @(posedge clk) tx_st <= 4'b1000;
        rd(OFS_STATUS, v); chk(v, 32'h18);
        @(posedge clk) tx_st <= 4'b0101;
        rd(OFS_STATUS, v); chk(v, 32'h18);
        @(posedge clk) tx_st <= 4'b0010;
        rd(OFS_STATUS, v); chk(v, 32'h1a);
        @(posedge clk) tx_st <= '0;
        ev(5'b10000); ev(5'b10000);
        rd(OFS_STATUS, v); chk(v, 32'h23b);
        wr(OFS_MASK_SET, 32'h20); repeat (2) @(posedge clk); #1 chk(irq, 1);
        ev(5'b01101);
        rd(OFS_STATUS, v); chk(v, 32'h2ff);
        wr(OFS_COMMAND, 32'h100);
        rd(OFS_STATUS, v); chk(v, 32'h21b);
        #1 chk(irq, 0);
        rd(OFS_RX_HOLD, v); chk(v, {23'h0, hp}); chk(hrc, 1);
        rd(OFS_STATUS, v); chk(v, 32'h21a);
        @(posedge clk) begin rx_xfer_end <= 0; tx_xfer_end <= 0; end
        rd(OFS_STATUS, v); chk(v, 32'h202);
        @(posedge clk) begin rx_xfer_end <= 1; tx_xfer_end <= 1; end
        wr(OFS_COMMAND, 32'h80); #1 chk({rxe, txe}, 2'b10);
        rd(OFS_STATUS, v); chk(v, 32'h18);
        wr(OFS_IDLE_TIME, 32'h5); #1 chk({iws, idle_val}, 9'h105);
        @(posedge clk) to_exp <= 1'b1;
        @(posedge clk) to_exp <= 1'b0;
        rd(OFS_STATUS, v); chk(v, 32'h118);
        wr(OFS_COMMAND, 32'h800); #1 chk(iws, 1);
        rd(OFS_STATUS, v); chk(v, 32'h18);
        // ready then disable, then a character and a multi-drop high parity bit
        ev(5'b10000);
        wr(OFS_COMMAND, 32'h20); #1 chk({rxe, txe}, 2'b00);
        wr(OFS_MODE, 32'hc00);
        ev(5'b10010);
        rd(OFS_STATUS, v); chk(v, 32'h98);
        wr(OFS_COMMAND, 32'h100);
        rd(OFS_STATUS, v); chk(v, 32'h18);
        for (i = 0; i < 6; i++) begin
            w = $random(seed) & MODE_WR_MASK & ~32'hc000; wr(OFS_MODE, w);
            repeat (2) @(posedge clk); #1 chk(sck_oe, w[18] & ~w[5]);
            chk(char_bits, w[17] ? BITS_NINE : BITS_BASE + w[7:6]);
        end
        @(posedge clk) en <= 1'b1;
        for (k = 0; k < 4; k++) begin
            wr(OFS_MODE, k << 14);
            repeat (64) begin
                @(posedge clk); #1 chk(sck_out, bp);
                v = loop_exp(k, rxd_pin, tx_serial);
                // skip edges where the pin or tx_serial just moved past the pipeline
                if (cyc % 8 > 5 || cyc % 8 == 3 || cyc % 8 == 4)
                    chk({txd_pin, rx_serial}, v);
            end
        end
        finish_test;
    end
endmodule : usi_status_top_bench
